// file: hw/rpd_consts.vh
`ifndef RPD_CONSTS_VH
`define RPD_CONSTS_VH
// register byte offsets
`define RPD_OFF_CTRL 4'h0
`define RPD_OFF_FILT 4'h4
`define RPD_OFF_POS 4'h8
`define RPD_OFF_STAT 4'hc
// ctrl field positions
`define RPD_CTRL_FORM_LSB 0
`define RPD_CTRL_INV_LSB 4
`define RPD_CTRL_MODE_LSB 8
`define RPD_CTRL_CLR_BIT 12
// filt field positions
`define RPD_FILT_SEL_LSB 0
`define RPD_FILT_ENC_LSB 4
`define RPD_FILT_NOISE_BIT 8
// reset values
`define RPD_CTRL_RST 32'h0000_0000
`define RPD_FILT_RST 32'h0000_0003
// pulse forms
`define RPD_FORM_STEP_DIR 3'h0
`define RPD_FORM_FWD_REV 3'h1
`define RPD_FORM_QUAD_X1 3'h2
`define RPD_FORM_QUAD_X2 3'h3
`define RPD_FORM_QUAD_X4 3'h4
// control mode: position control with pulse train reference
`define RPD_MODE_PULSE_POS 4'h1
// input frequency limits in kHz, encoder types 3..5 and 6
`define RPD_FMAX_A0_KHZ 4000
`define RPD_FMAX_A1_KHZ 650
`define RPD_FMAX_A2_KHZ 150
`define RPD_FMAX_B0_KHZ 700
`define RPD_FMAX_B1_KHZ 200
`define RPD_FMAX_B2_KHZ 60
`define RPD_CLK_KHZ 20000
// stable-cycles per filter: half the shortest period, rounded down, min 1
`define RPD_CYC(f) (((`RPD_CLK_KHZ / (f)) / 2) < 1 ? 1 : \
  ((`RPD_CLK_KHZ / (f)) / 2))
// extra stable cycles added by the noise filter
`define RPD_NOISE_EXTRA 8
`endif

// file: hw/rpd_glitch_filter.v
`timescale 1ns/1ns
// accepts a new level only after it has been stable for limit cycles
module rpd_glitch_filter #(
  parameter W = 8
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // data
  input wire din,
  input wire [W-1:0] limit,
  output reg dout
);
  reg [W-1:0] cnt;

  // counter restarts whenever input agrees with the held output
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= {W{1'b0}};
      dout <= 1'b0;
    end
    else if (din == dout)
      cnt <= {W{1'b0}};
    else if (cnt + {{(W-1){1'b0}}, 1'b1} >= limit)
    begin
      dout <= din;
      cnt <= {W{1'b0}};
    end
    else
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// file: hw/rpd_reference_pulse_decoder.v
// Function
// - pulse counting only when control mode selects pulse-train position.
// - encoder types 3..5: filter 0/1/2 pass up to 4M, 650k, 150k.
// - encoder type 6: filter 0/1/2 pass up to 700k, 200k, 60k.
// - form 0 step+dir, 1 fwd/rev trains, 2/3/4 quadrature x1/x2/x4.
// - multiplier applies only to quadrature forms.
// - inversion 0 none, 1 direction, 2 step, 3 both lines.
// - step+dir: direction high is forward, low is reverse.
// - quadrature: B leading A counts forward, B lagging counts reverse.
// - an extra noise filter setting is offered for open collector.
// - clear held low zeroes the error counter, stops position loop.
`timescale 1ns/1ns
`include "rpd_consts.vh"
module rpd_reference_pulse_decoder #(
  parameter CW = 32
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // reference lines from the host
  input wire step_in,
  input wire dir_in,
  input wire error_counter_clear_n,
  // position reference outputs
  output reg ref_fwd,
  output reg ref_rev,
  output reg loop_enable,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [1:0] RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10;
  localparam integer LIM_A0 = `RPD_CYC(`RPD_FMAX_A0_KHZ);
  localparam integer LIM_A1 = `RPD_CYC(`RPD_FMAX_A1_KHZ);
  localparam integer LIM_A2 = `RPD_CYC(`RPD_FMAX_A2_KHZ); // over six bits
  localparam integer LIM_B0 = `RPD_CYC(`RPD_FMAX_B0_KHZ);
  localparam integer LIM_B1 = `RPD_CYC(`RPD_FMAX_B1_KHZ);
  localparam integer LIM_B2 = `RPD_CYC(`RPD_FMAX_B2_KHZ); // over six bits
  localparam integer NOISE_EXTRA = `RPD_NOISE_EXTRA;
  // write channel states, one-hot
  localparam [2:0] W_IDLE = 3'b001, W_HAVE = 3'b010, W_RESP = 3'b100;
  reg [31:0] ctrl, filt, w_data;
  reg [CW-1:0] position;
  reg [2:0] wstate;
  reg aw_got, w_got, a_prev, b_prev;
  reg [3:0] aw_addr, w_strb;
  reg [1:0] sync_step, sync_dir, sync_clr;
  reg [7:0] next_limit;
  reg next_fwd, next_rev;
  wire [2:0] form = ctrl[`RPD_CTRL_FORM_LSB +: 3];
  wire [1:0] inv = ctrl[`RPD_CTRL_INV_LSB +: 2];
  wire [3:0] mode = ctrl[`RPD_CTRL_MODE_LSB +: 4];
  wire [1:0] fsel = filt[`RPD_FILT_SEL_LSB +: 2];
  wire [3:0] enc = filt[`RPD_FILT_ENC_LSB +: 4];
  wire noise_filter_field = filt[`RPD_FILT_NOISE_BIT];
  wire pulse_mode = (mode == `RPD_MODE_PULSE_POS);
  wire clr_active = ~sync_clr[1] | ctrl[`RPD_CTRL_CLR_BIT];
  wire a_filt, b_filt, a_line, b_line;
  // two-stage synchronisers for the pins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_step <= 2'b00;
      sync_dir <= 2'b00;
      sync_clr <= 2'b11;
    end
    else
    begin
      sync_step <= {sync_step[0], step_in};
      sync_dir <= {sync_dir[0], dir_in};
      sync_clr <= {sync_clr[0], error_counter_clear_n};
    end
  end

  // filter stability window chosen by encoder type and filter setting
  always @*
  begin
    if (enc == 4'h6)
    begin
      case (fsel)
        2'h0: next_limit = LIM_B0[7:0];
        2'h1: next_limit = LIM_B1[7:0];
        default: next_limit = LIM_B2[7:0];
      endcase
    end
    else
    begin
      case (fsel)
        2'h0: next_limit = LIM_A0[7:0];
        2'h1: next_limit = LIM_A1[7:0];
        default: next_limit = LIM_A2[7:0];
      endcase
    end
    if (noise_filter_field)
      next_limit = next_limit + NOISE_EXTRA[7:0];
  end

  // one filter each for the step and direction lines
  rpd_glitch_filter #(.W(8)) u_filt_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(sync_step[1]),
    .limit(next_limit),
    .dout(a_filt)
  );
  rpd_glitch_filter #(.W(8)) u_filt_dir (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(sync_dir[1]),
    .limit(next_limit),
    .dout(b_filt)
  );

  // polarity: bit0 inverts direction, bit1 inverts step
  assign b_line = b_filt ^ inv[0];
  assign a_line = a_filt ^ inv[1];
  // decode one count per cycle; a and b edges are tracked together
  always @*
  begin
    next_fwd = 1'b0;
    next_rev = 1'b0;
    case (form)
      `RPD_FORM_STEP_DIR, `RPD_FORM_QUAD_X1:
      begin
        // rising step or phase a; other line sets the way; no multiplier
        if (a_line && !a_prev)
        begin
          next_fwd = b_line;
          next_rev = ~b_line;
        end
      end
      `RPD_FORM_FWD_REV:
      begin
        next_fwd = a_line & ~a_prev;
        next_rev = b_line & ~b_prev;
      end
      `RPD_FORM_QUAD_X2:
      begin
        if (a_line != a_prev)
        begin
          next_fwd = (a_line == b_line);
          next_rev = (a_line != b_line);
        end
      end
      `RPD_FORM_QUAD_X4:
      begin
        // both phases; a simultaneous change of both is an illegal jump
        if ((a_line != a_prev) && (b_line == b_prev))
        begin
          next_fwd = (a_line == b_line);
          next_rev = (a_line != b_line);
        end
        else if ((b_line != b_prev) && (a_line == a_prev))
        begin
          next_fwd = (a_line != b_line);
          next_rev = (a_line == b_line);
        end
      end
      default:
        next_fwd = 1'b0;
    endcase
  end
  // reference outputs and the error position counter
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      ref_fwd <= 1'b0;
      ref_rev <= 1'b0;
      loop_enable <= 1'b0;
      position <= {CW{1'b0}};
    end
    else
    begin
      a_prev <= a_line;
      b_prev <= b_line;
      // forward and reverse together cancel, so neither is reported
      ref_fwd <= pulse_mode & next_fwd & ~next_rev;
      ref_rev <= pulse_mode & next_rev & ~next_fwd;
      loop_enable <= pulse_mode & ~clr_active;
      if (clr_active)
        position <= {CW{1'b0}};
      else if (pulse_mode && next_fwd && !next_rev)
        position <= position + {{(CW-1){1'b0}}, 1'b1};
      else if (pulse_mode && next_rev && !next_fwd)
        position <= position - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // write path: address and data in either order, then response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate <= W_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl <= `RPD_CTRL_RST;
      filt <= `RPD_FILT_RST;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      case (wstate)
        W_IDLE:
        begin
          if (s_axi_awvalid && !aw_got && !s_axi_awready)
          begin
            s_axi_awready <= 1'b1;
            aw_addr <= s_axi_awaddr;
            aw_got <= 1'b1;
          end
          if (s_axi_wvalid && !w_got && !s_axi_wready)
          begin
            s_axi_wready <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_got <= 1'b1;
          end
          if (aw_got && w_got)
            wstate <= W_HAVE;
        end
        W_HAVE:
        begin
          // only ctrl and filt are writable
          s_axi_bresp <= RESP_OKAY;
          if (aw_addr == `RPD_OFF_CTRL)
          begin
            if (w_strb[0])
              ctrl[7:0] <= w_data[7:0];
            if (w_strb[1])
              ctrl[15:8] <= w_data[15:8];
          end
          else if (aw_addr == `RPD_OFF_FILT)
          begin
            if (w_strb[0])
              filt[7:0] <= w_data[7:0];
            if (w_strb[1])
              filt[15:8] <= w_data[15:8];
          end
          else if (aw_addr != `RPD_OFF_POS && aw_addr != `RPD_OFF_STAT)
            s_axi_bresp <= RESP_SLVERR;
          s_axi_bvalid <= 1'b1;
          aw_got <= 1'b0;
          w_got <= 1'b0;
          wstate <= W_RESP;
        end
        W_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wstate <= W_IDLE;
          end
        end
        default:
          wstate <= W_IDLE;
      endcase
    end
  end

  // read path: one cycle to accept, data valid in that same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid)
      begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          `RPD_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl[15:0]};
          `RPD_OFF_FILT: s_axi_rdata <= {16'h0000, filt[15:0]};
          `RPD_OFF_POS: s_axi_rdata <= position[31:0];
          `RPD_OFF_STAT: s_axi_rdata <= {28'h0000000, loop_enable,
            clr_active, b_line, a_line};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

// file: testbench/rpd_chk.sv
`timescale 1ns/1ns
// pulse and bus relations seen at the decoder ports
module rpd_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pins and references
  input wire error_counter_clear_n,
  input wire ref_fwd,
  input wire ref_rev,
  input wire loop_enable,
  // bus handshakes
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg [7:0] clr_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // clear length; margin covers sync and register delay on the pin
  always @(posedge aclk)
  begin
    if (!aresetn || error_counter_clear_n)
      clr_cnt <= 8'h00;
    else if (clr_cnt != 8'hff)
      clr_cnt <= clr_cnt + 8'h01;
  end
  a_refs_apart: assert property (!(ref_fwd && ref_rev))
    else $error("both refs high");
  a_fwd_single: assert property (ref_fwd |=> !ref_fwd)
    else $error("ref_fwd too long");
  a_rev_single: assert property (ref_rev |=> !ref_rev)
    else $error("ref_rev too long");
  a_clear_stops: assert property (clr_cnt > 8'h20 |-> !loop_enable)
    else $error("loop on in clear");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
  a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid kept");
  a_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept");
  a_read_lat: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read late");
  a_write_lat: assert property ($rose(s_axi_awready) |-> ##2 s_axi_bvalid)
    else $error("write late");
  c_fwd: cover property (ref_fwd);
  c_rev: cover property (ref_rev);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind rpd_reference_pulse_decoder rpd_chk u_chk (.aclk, .aresetn,
  .error_counter_clear_n, .ref_fwd, .ref_rev, .loop_enable, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

// file: testbench/rpd_host_model.sv
`timescale 1ns/1ns
// host pulse source; always drives both lines, no release
module rpd_host_model (
  // clock
  input wire aclk,
  // reference lines
  output reg step_line = 1'b0,
  output reg dir_line = 1'b0
);
  // park both lines at given levels
  task set_lines(input reg s, input reg d);
    @(posedge aclk);
    step_line <= s;
    dir_line <= d;
  endtask
  // n pulses of w cycles; leading gap gives direction setup time
  task pulses(input reg on_dir, input integer n,
    input integer w);
    repeat (2 * n)
    begin
      repeat (w) @(posedge aclk);
      if (on_dir) dir_line <= !dir_line;
      else step_line <= !step_line;
    end
  endtask
  // quarter of 26 cycles stays under 4000 kpps even at x4
  task quad(input integer n, input reg fwd);
    integer i;
    repeat (n)
      for (i = 0; i < 4; i = i + 1)
      begin
        @(posedge aclk);
        step_line <= fwd ? (i == 1 || i == 2) : (i < 2);
        dir_line <= fwd ? (i < 2) : (i == 1 || i == 2);
        repeat (25) @(posedge aclk);
      end
  endtask
endmodule

// file: testbench/test_reference_pulse_decoder.sv
`timescale 1ns/1ns
`include "rpd_consts.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("Error %s: expected %h, seen %h", n, e, a); end end
module test_reference_pulse_decoder;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg error_counter_clear_n = 1'b1;
  reg [3:0] s_axi_awaddr = 4'h0;
  reg [3:0] s_axi_araddr = 4'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  wire step_in, dir_in, ref_fwd, ref_rev, loop_enable;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer num_errors = 0;
  integer num_checks = 0;
  integer k;
  reg [31:0] d;
  reg [1:0] r;
  // filter setting, pulse width and expected count per row
  int fv[9] = '{9'h001, 9'h001, 9'h060, 9'h060, 9'h100, 9'h000, 9'h002,
    9'h002, 9'h062};
  int fw[9] = '{8, 20, 8, 20, 6, 6, 40, 70, 100};
  int fx[9] = '{0, 1, 0, 1, 0, 1, 0, 1, 0};

  always #25 aclk = !aclk;

  rpd_host_model u_host (.aclk, .step_line(step_in), .dir_line(dir_in));
  rpd_reference_pulse_decoder u_dut (.aclk, .aresetn, .step_in, .dir_in,
    .error_counter_clear_n, .ref_fwd, .ref_rev, .loop_enable, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // address and data offered together, each dropped when taken; bresp in r
  task wr(input [3:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read result lands in d and r
  task rd(input [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // reconfigure under clear so line moves cannot count
  task setup(input [31:0] ctrl, input reg s, input reg dl);
    @(posedge aclk);
    error_counter_clear_n <= 1'b0;
    wr(`RPD_OFF_CTRL, ctrl);
    u_host.set_lines(s, dl);
    repeat (40) @(posedge aclk);
    `CHK("loop_enable", 1'b0, loop_enable)
    rd(`RPD_OFF_POS);
    `CHK("position in clear", 32'h0, d)
    error_counter_clear_n <= 1'b1;
    repeat (20) @(posedge aclk);
  endtask
  task expect_pos(input [31:0] e);
    repeat (20) @(posedge aclk);
    rd(`RPD_OFF_POS);
    `CHK("position", e, d)
    $display("test done, position %0d", $signed(d));
  endtask

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RPD_OFF_CTRL);
    `CHK("ctrl reset", `RPD_CTRL_RST, d)
    rd(`RPD_OFF_FILT);
    `CHK("filt reset", `RPD_FILT_RST, d)
    rd(4'h2);
    `CHK("unmapped rresp", 2'h2, r)
    wr(4'h2, 32'h0);
    `CHK("unmapped bresp", 2'h2, r)
    wr(`RPD_OFF_FILT, 32'h0);
    // wrong control mode ignores the lines
    setup(32'h0, 1'b0, 1'b1);
    u_host.pulses(1'b0, 3, 20);
    expect_pos(32'h0);
    // step plus direction, both ways
    setup(32'h100, 1'b0, 1'b1);
    `CHK("loop_enable", 1'b1, loop_enable)
    u_host.pulses(1'b0, 3, 20);
    u_host.set_lines(1'b0, 1'b0);
    u_host.pulses(1'b0, 5, 20);
    expect_pos(32'hffff_fffe);
    // separate trains
    setup(32'h101, 1'b0, 1'b0);
    u_host.pulses(1'b0, 2, 20);
    u_host.pulses(1'b1, 1, 20);
    expect_pos(32'h1);
    // quadrature: two forward cycles, one reverse
    for (k = 2; k < 5; k++)
    begin
      setup(32'h100 | k, 1'b0, 1'b0);
      u_host.quad(2, 1'b1);
      u_host.quad(1, 1'b0);
      expect_pos(1 << (k - 2));
    end
    // a single pin edge that inversion makes rise counts forward, for all four inversion settings
    for (k = 0; k < 4; k++)
    begin
      setup(32'h100 | (k << 4), k[1], !k[0]);
      u_host.set_lines(!k[1], !k[0]);
      expect_pos(32'h1);
    end
    // short pulses dropped, long enough ones counted
    for (k = 0; k < 9; k++)
    begin
      wr(`RPD_OFF_FILT, fv[k]);
      setup(32'h100, 1'b0, 1'b1);
      u_host.pulses(1'b0, 1, fw[k]);
      expect_pos(fx[k]);
    end
    summarize;
  end

  // whole run needs well under 10000 cycles
  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    summarize;
  end

  task summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
endmodule
